// ==== verilog/spmf_core.sv ====
// serial port controller, master or slave, with tx and rx word fifos
// assumes configuration ports are static during a word, strobes last one cycle
module spmf_core (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// configuration
	input wire logic ctrl_enable_bit,
	input wire logic slave_select_mode_bit,
	input wire logic clock_polarity_bit,
	input wire logic clock_phase_bit,
	input wire logic [1:0] word_size_sel,
	input wire logic [1:0] clock_div_sel,
	input wire logic [1:0] fifo_mode_sel,
	input wire logic idle_level_bit,
	input wire logic engine_reset_bit,
	input wire logic force_output_bit,
	input wire logic chip_enable_ctrl_bit,
	input wire logic ninth_bit_cmd_data,
	input wire logic irq_mask_bit,
	// processor data access
	input wire logic data_low_wr,
	input wire logic data_high_wr,
	input wire logic [spmf_pkg::SPMF_HALF_W-1:0] wr_data,
	input wire logic data_low_rd,
	input wire logic irq_clear_wr,
	output logic [spmf_pkg::SPMF_HALF_W-1:0] data_low_register,
	output logic [spmf_pkg::SPMF_HALF_W-1:0] data_high_register,
	// status
	output logic tx_holding_full_flag,
	output logic irq_status_bit,
	output logic irq_pending_flag,
	output logic busy_flag,
	output logic irq,
	// dma requests
	output logic rx_dma_req,
	output logic tx_dma_req,
	// serial pins
	input wire logic serial_clock_in,
	output logic serial_clock_out,
	output logic serial_clock_oe,
	output logic serial_out_pin,
	input wire logic serial_in_pin,
	input wire logic first_port_chip_enable_n
);
	import spmf_pkg::*;
	// ****************
	// declarations
	// ****************
	spmf_state_t state_reg;
	logic [SPMF_WORD_W-1:0] shift_reg;
	logic [SPMF_WORD_W-1:0] shift_next;
	logic [SPMF_WORD_W-1:0] tx_data_reg;
	logic [SPMF_WORD_W-1:0] rx_data_reg;
	logic [SPMF_WORD_W-1:0] src_word;
	logic [SPMF_WORD_W-1:0] aligned;
	logic [SPMF_WORD_W-1:0] rx_word;
	logic [SPMF_WORD_W-1:0] wr_word;
	logic [SPMF_WORD_W-1:0] tx_head;
	logic [SPMF_WORD_W-1:0] rx_head;
	logic [SPMF_HALF_W-1:0] tx_high_reg;
	logic [SPMF_HALF_W-1:0] rx_low;
	logic [SPMF_CNT_W-1:0] bit_cnt_reg;
	logic [SPMF_CNT_W-1:0] cnt_next;
	logic [SPMF_CNT_W-1:0] nbits;
	logic [2:0] cap;
	logic hold_full_reg;
	logic sdo_reg;
	logic keep_last_reg;
	logic cs_n_q_reg;
	logic pend_reg;
	logic tx_fifo_on;
	logic rx_fifo_on;
	logic engine_clr;
	logic shifting;
	logic lead;
	logic trail;
	logic sample_edge;
	logic drive_edge;
	logic done_now;
	logic load_now;
	logic avail;
	logic cs_abort;
	logic gate_ok;
	logic irq_src;
	logic tx_full;
	logic tx_empty;
	logic rx_full;
	logic rx_empty;
	// ****************
	// mode decode
	// ****************
	assign tx_fifo_on = (fifo_mode_sel == SPMF_FM_BIDIR) || (fifo_mode_sel == SPMF_FM_WRONLY);
	assign rx_fifo_on = (fifo_mode_sel == SPMF_FM_BIDIR) || (fifo_mode_sel == SPMF_FM_RDONLY);
	// the engine stays parked until enabled, so configure first
	assign engine_clr = !ctrl_enable_bit || engine_reset_bit;
	assign nbits = SPMF_BITS_TAB[word_size_sel];
	assign cap = SPMF_CAP_TAB[word_size_sel];
	assign shifting = (state_reg == ST_SHIFT);
	assign gate_ok = !chip_enable_ctrl_bit || !first_port_chip_enable_n;
	assign wr_word = {tx_high_reg, wr_data};
	// ****************
	// word source and start
	// ****************
	assign src_word = tx_fifo_on ? tx_head : tx_data_reg;
	always_comb begin
		case (fifo_mode_sel)
			SPMF_FM_NONE: avail = hold_full_reg;
			SPMF_FM_WRONLY: avail = !tx_empty;
			SPMF_FM_RDONLY: avail = !rx_full;
			default: avail = !tx_empty && !rx_full;
		endcase
	end
	// a slave loads ahead and then waits for the far master's edges
	assign load_now = !shifting && !engine_clr && avail;
	always_comb begin
		case (word_size_sel)
			SPMF_WS_8: aligned = {src_word[7:0], 24'h0};
			SPMF_WS_16: aligned = {src_word[15:0], 16'h0};
			SPMF_WS_9: aligned = {ninth_bit_cmd_data, src_word[7:0], 23'h0};
			default: aligned = src_word;
		endcase
	end
	// ****************
	// serial clock and edges
	// ****************
	spmf_clkgen u_clkgen (
		.mclk(mclk),
		.srst(srst),
		.run(shifting),
		.slave(slave_select_mode_bit),
		.pol(clock_polarity_bit),
		.gate_ok(gate_ok),
		.div_sel(clock_div_sel),
		.sclk_in(serial_clock_in),
		.sclk_out(serial_clock_out),
		.lead(lead),
		.trail(trail)
	);
	assign serial_clock_oe = ctrl_enable_bit && !slave_select_mode_bit;
	assign sample_edge = shifting && (clock_phase_bit ? trail : lead);
	assign drive_edge = shifting && (clock_phase_bit ? lead : trail);
	assign cs_abort = shifting && slave_select_mode_bit && chip_enable_ctrl_bit && first_port_chip_enable_n
		&& !cs_n_q_reg && (bit_cnt_reg != 6'h00);
	// ****************
	// shift engine
	// ****************
	assign shift_next = sample_edge ? {shift_reg[SPMF_WORD_W-2:0], serial_in_pin} : shift_reg;
	assign cnt_next = sample_edge ? bit_cnt_reg + 6'h01 : bit_cnt_reg;
	assign done_now = shifting && trail && !cs_abort && (cnt_next == nbits);
	always_comb begin
		case (word_size_sel)
			SPMF_WS_16: rx_word = {16'h0, shift_next[15:0]};
			SPMF_WS_32: rx_word = shift_next;
			// the ninth bit has left the low byte and is dropped
			default: rx_word = {24'h0, shift_next[7:0]};
		endcase
	end
	assign rx_low = rx_word[SPMF_HALF_W-1:0];
	always_ff @(posedge mclk) begin
		if (srst || engine_clr) begin
			state_reg <= ST_IDLE;
			shift_reg <= SPMF_TX_RST;
			bit_cnt_reg <= 6'h00;
		end else if (load_now) begin
			state_reg <= ST_SHIFT;
			shift_reg <= aligned;
			bit_cnt_reg <= 6'h00;
		end else if (cs_abort) begin
			state_reg <= ST_IDLE;
			shift_reg <= SPMF_TX_RST;
			bit_cnt_reg <= 6'h00;
		end else if (shifting) begin
			shift_reg <= shift_next;
			bit_cnt_reg <= cnt_next;
			if (done_now)
				state_reg <= ST_IDLE;
		end
	end
	always_ff @(posedge mclk) begin
		if (srst)
			cs_n_q_reg <= SPMF_CS_N_RST;
		else
			cs_n_q_reg <= first_port_chip_enable_n;
	end
	// ****************
	// serial output
	// ****************
	always_ff @(posedge mclk) begin
		if (srst || engine_clr) begin
			sdo_reg <= 1'b0;
			keep_last_reg <= 1'b0;
		end else if (load_now) begin
			sdo_reg <= aligned[SPMF_WORD_W-1];
			keep_last_reg <= 1'b0;
		end else begin
			if (drive_edge && !done_now)
				sdo_reg <= shift_reg[SPMF_WORD_W-1];
			if (done_now)
				keep_last_reg <= clock_phase_bit;
		end
	end
	always_comb begin
		if (force_output_bit)
			serial_out_pin = idle_level_bit;
		else if (shifting || keep_last_reg)
			serial_out_pin = sdo_reg;
		else
			serial_out_pin = idle_level_bit;
	end
	// ****************
	// transmit side
	// ****************
	always_ff @(posedge mclk) begin
		if (srst) begin
			tx_data_reg <= SPMF_TX_RST;
			tx_high_reg <= SPMF_TX_RST[SPMF_HALF_W-1:0];
		end else begin
			if (data_high_wr)
				tx_high_reg <= wr_data;
			if (data_low_wr)
				tx_data_reg <= wr_word;
		end
	end
	// a write in the same cycle as a load re-arms the flag
	always_ff @(posedge mclk) begin
		if (srst)
			hold_full_reg <= 1'b0;
		else if (data_low_wr && fifo_mode_sel == SPMF_FM_NONE)
			hold_full_reg <= 1'b1;
		else if (load_now && fifo_mode_sel == SPMF_FM_NONE)
			hold_full_reg <= 1'b0;
	end
	spmf_fifo u_tx_fifo (
		.mclk(mclk),
		.srst(srst),
		.flush(engine_reset_bit),
		.cap(cap),
		.push(data_low_wr && tx_fifo_on),
		.push_data(wr_word),
		.pop(load_now && tx_fifo_on),
		.head(tx_head),
		.full(tx_full),
		.empty(tx_empty)
	);
	// ****************
	// receive side
	// ****************
	// without an rx fifo an unread word is simply overwritten
	always_ff @(posedge mclk) begin
		if (srst)
			rx_data_reg <= SPMF_TX_RST;
		else if (done_now && !rx_fifo_on) begin
			rx_data_reg[SPMF_HALF_W-1:0] <= rx_low;
			if (word_size_sel == SPMF_WS_32)
				rx_data_reg[SPMF_WORD_W-1:SPMF_HALF_W] <= rx_word[SPMF_WORD_W-1:SPMF_HALF_W];
		end
	end
	spmf_fifo u_rx_fifo (
		.mclk(mclk),
		.srst(srst),
		.flush(engine_reset_bit),
		.cap(cap),
		.push(done_now && rx_fifo_on),
		.push_data(rx_word),
		.pop(data_low_rd && rx_fifo_on),
		.head(rx_head),
		.full(rx_full),
		.empty(rx_empty)
	);
	assign data_low_register = rx_fifo_on ? rx_head[SPMF_HALF_W-1:0] : rx_data_reg[SPMF_HALF_W-1:0];
	assign data_high_register = rx_fifo_on ? rx_head[SPMF_WORD_W-1:SPMF_HALF_W]
		: rx_data_reg[SPMF_WORD_W-1:SPMF_HALF_W];
	// ****************
	// status and requests
	// ****************
	always_ff @(posedge mclk) begin
		if (srst)
			pend_reg <= 1'b0;
		else if (done_now)
			pend_reg <= 1'b1;
		else if (irq_clear_wr)
			pend_reg <= 1'b0;
	end
	always_comb begin
		case (fifo_mode_sel)
			SPMF_FM_WRONLY: irq_src = !tx_full;
			SPMF_FM_NONE: irq_src = pend_reg;
			default: irq_src = pend_reg || !rx_empty;
		endcase
	end
	assign irq_status_bit = irq_src;
	assign irq_pending_flag = pend_reg;
	assign irq = irq_src && !irq_mask_bit;
	assign tx_holding_full_flag = tx_fifo_on ? tx_full : hold_full_reg;
	assign busy_flag = shifting || (tx_fifo_on && !tx_empty) || (fifo_mode_sel == SPMF_FM_NONE && hold_full_reg)
		|| (fifo_mode_sel == SPMF_FM_RDONLY && ctrl_enable_bit && !slave_select_mode_bit && !rx_full);
	// tx request stands once the mode is entered and enabled and drops while the tx fifo is full; rx request waits for a received word
	assign tx_dma_req = ctrl_enable_bit && tx_fifo_on && !tx_full;
	assign rx_dma_req = ctrl_enable_bit && rx_fifo_on && !rx_empty;
	// ****************
	// checks
	// ****************
	property p_hold_set;
		@(posedge mclk) disable iff (srst) data_low_wr && fifo_mode_sel == SPMF_FM_NONE |=> tx_holding_full_flag;
	endproperty
	a_hold_set: assert property (p_hold_set) else $error("holding flag not set by low write");
	property p_load_clr;
		@(posedge mclk) disable iff (srst) load_now && fifo_mode_sel == SPMF_FM_NONE && !data_low_wr
			|=> !tx_holding_full_flag && shifting;
	endproperty
	a_load_clr: assert property (p_load_clr) else $error("load did not clear holding flag");
	property p_shift_in;
		@(posedge mclk) disable iff (srst || engine_clr) sample_edge && !cs_abort |=> shift_reg[0] == $past(serial_in_pin);
	endproperty
	a_shift_in: assert property (p_shift_in) else $error("input bit not shifted in");
	property p_done_pend;
		@(posedge mclk) disable iff (srst) done_now |=> irq_pending_flag && !shifting;
	endproperty
	a_done_pend: assert property (p_done_pend) else $error("word end did not set pending");
	property p_copy_low;
		@(posedge mclk) disable iff (srst) done_now && !rx_fifo_on |=> data_low_register == $past(rx_low);
	endproperty
	a_copy_low: assert property (p_copy_low) else $error("received word not copied");
	property p_mask;
		@(posedge mclk) disable iff (srst) fifo_mode_sel == SPMF_FM_BIDIR && !rx_empty |-> irq == !irq_mask_bit;
	endproperty
	a_mask: assert property (p_mask) else $error("rx data interrupt or mask wrong");
	property p_wronly_req;
		@(posedge mclk) disable iff (srst) fifo_mode_sel == SPMF_FM_WRONLY |-> irq_status_bit != tx_holding_full_flag;
	endproperty
	a_wronly_req: assert property (p_wronly_req) else $error("writes-only request not inverse of full");
	property p_abort;
		@(posedge mclk) disable iff (srst) cs_abort |=> bit_cnt_reg == 6'h00 && !shifting;
	endproperty
	a_abort: assert property (p_abort) else $error("chip enable release did not reset buffer");
	property p_idle_pha0;
		@(posedge mclk) disable iff (srst) done_now && !clock_phase_bit |=> force_output_bit
			|| serial_out_pin == idle_level_bit;
	endproperty
	a_idle_pha0: assert property (p_idle_pha0) else $error("output not at idle level");
	property p_keep_last;
		@(posedge mclk) disable iff (srst || engine_clr) done_now && clock_phase_bit && !force_output_bit
			|=> force_output_bit || serial_out_pin == $past(serial_out_pin);
	endproperty
	a_keep_last: assert property (p_keep_last) else $error("last bit not kept");
	property p_ninth;
		@(posedge mclk) disable iff (srst) load_now && word_size_sel == SPMF_WS_9
			|=> shift_reg[SPMF_WORD_W-1] == $past(ninth_bit_cmd_data);
	endproperty
	a_ninth: assert property (p_ninth) else $error("ninth bit not first");
	property p_rd_full;
		@(posedge mclk) disable iff (srst) fifo_mode_sel == SPMF_FM_RDONLY && rx_full && !shifting
			&& !slave_select_mode_bit |-> !busy_flag;
	endproperty
	a_rd_full: assert property (p_rd_full) else $error("busy with rx fifo full");
endmodule // spmf_core

// ==== verilog/spmf_pkg.sv ====
// constants and types of the serial port block
// assumes one clock mclk and a synchronous reset srst
package spmf_pkg;
	// ****************
	// widths and depth
	// ****************
	localparam int SPMF_WORD_W = 32;
	localparam int SPMF_HALF_W = 16;
	localparam int SPMF_FIFO_D = 4;
	localparam int SPMF_CNT_W = 6;
	// ****************
	// field codes
	// ****************
	localparam logic [1:0] SPMF_WS_8 = 2'h0;
	localparam logic [1:0] SPMF_WS_16 = 2'h1;
	localparam logic [1:0] SPMF_WS_32 = 2'h2;
	localparam logic [1:0] SPMF_WS_9 = 2'h3;
	localparam logic [1:0] SPMF_FM_BIDIR = 2'h0;
	localparam logic [1:0] SPMF_FM_RDONLY = 2'h1;
	localparam logic [1:0] SPMF_FM_WRONLY = 2'h2;
	localparam logic [1:0] SPMF_FM_NONE = 2'h3;
	localparam logic [1:0] SPMF_DIV_2 = 2'h0;
	localparam logic [1:0] SPMF_DIV_14 = 2'h3;
	// ****************
	// lookup tables, indexed by field code
	// ****************
	// sclk half period in mclk cycles for divide by 2, 4, 8, 14
	localparam logic [2:0] SPMF_HALF_TAB [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
	// bits per word for 8, 16, 32, 9
	localparam logic [5:0] SPMF_BITS_TAB [4] = '{6'h08, 6'h10, 6'h20, 6'h09};
	// fifo depth in words for 8, 16, 32, 9
	localparam logic [2:0] SPMF_CAP_TAB [4] = '{3'h4, 3'h2, 3'h1, 3'h4};
	// ****************
	// reset values
	// ****************
	localparam logic [31:0] SPMF_TX_RST = 32'h0;
	localparam logic SPMF_CS_N_RST = 1'b1;
	typedef enum logic {ST_IDLE, ST_SHIFT} spmf_state_t;
endpackage

// ==== verilog/spmf_fifo.sv ====
// word fifo of flip-flops whose usable depth follows the word size
// assumes push and pop are one-cycle strobes on mclk
module spmf_fifo (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// control
	input wire logic flush,
	input wire logic [2:0] cap,
	// fill side
	input wire logic push,
	input wire logic [spmf_pkg::SPMF_WORD_W-1:0] push_data,
	// drain side
	input wire logic pop,
	output logic [spmf_pkg::SPMF_WORD_W-1:0] head,
	output logic full,
	output logic empty
);
	import spmf_pkg::*;
	logic [SPMF_WORD_W-1:0] mem_reg [SPMF_FIFO_D];
	logic [1:0] wr_ptr_reg;
	logic [1:0] rd_ptr_reg;
	logic [2:0] count_reg;
	logic do_push;
	logic do_pop;
	assign full = (count_reg >= cap);
	assign empty = (count_reg == 3'h0);
	// a push while full is dropped, the sender sees full
	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	assign head = mem_reg[rd_ptr_reg];
	always_ff @(posedge mclk) begin
		if (srst || flush) begin
			wr_ptr_reg <= 2'h0;
			rd_ptr_reg <= 2'h0;
			count_reg <= 3'h0;
		end else begin
			if (do_push)
				wr_ptr_reg <= wr_ptr_reg + 2'h1;
			if (do_pop)
				rd_ptr_reg <= rd_ptr_reg + 2'h1;
			if (do_push && !do_pop)
				count_reg <= count_reg + 3'h1;
			else if (do_pop && !do_push)
				count_reg <= count_reg - 3'h1;
		end
	end
	always_ff @(posedge mclk) begin
		if (do_push)
			mem_reg[wr_ptr_reg] <= push_data;
	end
	property p_full_hold;
		@(posedge mclk) disable iff (srst || flush) full && push && !pop |=> count_reg == $past(count_reg);
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("push while full changed the fill level");
endmodule // spmf_fifo

// ==== verilog/spmf_clkgen.sv ====
// serial clock divider for master and edge detector for slave
// assumes the slave clock input is synchronous and slow against mclk
module spmf_clkgen (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// control
	input wire logic run,
	input wire logic slave,
	input wire logic pol,
	input wire logic gate_ok,
	input wire logic [1:0] div_sel,
	// serial clock
	input wire logic sclk_in,
	output logic sclk_out,
	// edge strobes
	output logic lead,
	output logic trail
);
	import spmf_pkg::*;
	logic [2:0] half;
	logic [2:0] div_cnt_reg;
	logic phase_reg;
	logic sclk_q_reg;
	logic tick;
	logic s_edge;
	assign half = SPMF_HALF_TAB[div_sel];
	assign tick = run && !slave && (div_cnt_reg == half - 3'h1);
	always_ff @(posedge mclk) begin
		if (srst || !run || slave) begin
			div_cnt_reg <= 3'h0;
			phase_reg <= 1'b0;
		end else if (tick) begin
			div_cnt_reg <= 3'h0;
			phase_reg <= !phase_reg;
		end else
			div_cnt_reg <= div_cnt_reg + 3'h1;
	end
	always_ff @(posedge mclk) begin
		if (srst)
			sclk_q_reg <= 1'b0;
		else
			sclk_q_reg <= sclk_in;
	end
	// one sample per mclk: the far clock must be well below mclk
	assign s_edge = slave && gate_ok && (sclk_in != sclk_q_reg);
	assign lead = tick ? !phase_reg : (s_edge && (sclk_in != pol));
	assign trail = tick ? phase_reg : (s_edge && (sclk_in == pol));
	assign sclk_out = pol ^ phase_reg;
	sequence s_half14;
		lead ##1 (!lead && !trail) [*6] ##1 trail;
	endsequence
	property p_div2;
		@(posedge mclk) disable iff (srst) run && !slave && div_sel == SPMF_DIV_2 && lead |=> trail;
	endproperty
	a_div2: assert property (p_div2) else $error("divide by 2 half period wrong");
	property p_div14;
		@(posedge mclk) disable iff (srst) run && !slave && div_sel == SPMF_DIV_14 && lead |-> s_half14;
	endproperty
	a_div14: assert property (p_div14) else $error("divide by 14 half period wrong");
	property p_sclk_idle;
		@(posedge mclk) disable iff (srst) !run ##1 !run |-> sclk_out == pol;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("idle clock level not polarity");
endmodule // spmf_clkgen

// ==== dv/spmf_slave_model.sv ====
// far-side serial peer, msb first, any clock mode
// assumes sclk comes from the master or the bench and never moves while load is high
module spmf_slave_model (
	// serial side
	input wire logic sclk,
	input wire logic mosi,
	output logic miso,
	// setup from bench
	input wire logic pol,
	input wire logic pha,
	input wire logic load,
	input wire logic [31:0] tx_word,
	output logic [31:0] rx_word
);
	timeunit 1ns;
	timeprecision 1ns;
	logic first = 1'b0;
	logic [31:0] sh = 32'h0;
	// rotating keeps repeated patterns valid across streamed words
	assign miso = sh[31];
	// reacts on the clock itself so a divide by 2 master still sees each bit in time
	always @(sclk or posedge load) begin
		if (load) begin
			sh <= tx_word;
			first <= 1'b1;
			rx_word <= 32'h0;
		end else if ((sclk != pol) != pha) begin
			rx_word <= {rx_word[30:0], mosi};
		end else if (first && pha) begin
			first <= 1'b0;
		end else begin
			sh <= {sh[30:0], sh[31]};
		end
	end
endmodule // spmf_slave_model

// ==== dv/spi_master_slave_fifo_port_test.sv ====
// self-checking bench for spmf_core in master and slave operation
// assumes spmf_pkg and spmf_slave_model are compiled first
module spi_master_slave_fifo_port_test;
	timeunit 1ns;
	timeprecision 1ns;
	import spmf_pkg::*;
	logic mclk = 1'b0, srst = 1'b1, ctrl_enable_bit = 1'b0, slave_select_mode_bit = 1'b0, load = 1'b0;
	logic clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0, idle_level_bit = 1'b0, engine_reset_bit = 1'b0;
	logic force_output_bit = 1'b0, chip_enable_ctrl_bit = 1'b0, ninth_bit_cmd_data = 1'b0, irq_mask_bit = 1'b0;
	logic data_low_wr = 1'b0, data_high_wr = 1'b0, data_low_rd = 1'b0, irq_clear_wr = 1'b0;
	logic serial_clock_in = 1'b0, first_port_chip_enable_n = 1'b1;
	logic [1:0] word_size_sel = 2'h0, clock_div_sel = 2'h0, fifo_mode_sel = 2'h3;
	logic [15:0] wr_data = 16'h0, data_low_register, data_high_register;
	logic tx_holding_full_flag, irq_status_bit, irq_pending_flag, busy_flag, irq, rx_dma_req, tx_dma_req;
	logic serial_clock_out, serial_clock_oe, serial_out_pin, serial_in_pin;
	logic [31:0] s_word = 32'h0, m_word;
	int n_fail = 0, check_count = 0, cyc = 0;
	always #5 mclk = ~mclk;
	spmf_core dut_u (.mclk, .srst, .ctrl_enable_bit, .slave_select_mode_bit, .clock_polarity_bit,
		.clock_phase_bit, .word_size_sel, .clock_div_sel, .fifo_mode_sel, .idle_level_bit, .engine_reset_bit,
		.force_output_bit, .chip_enable_ctrl_bit, .ninth_bit_cmd_data, .irq_mask_bit, .data_low_wr, .data_high_wr,
		.wr_data, .data_low_rd, .irq_clear_wr, .data_low_register, .data_high_register, .tx_holding_full_flag,
		.irq_status_bit, .irq_pending_flag, .busy_flag, .irq, .rx_dma_req, .tx_dma_req, .serial_clock_in,
		.serial_clock_out, .serial_clock_oe, .serial_out_pin, .serial_in_pin, .first_port_chip_enable_n);
	spmf_slave_model far_u (.sclk(slave_select_mode_bit ? serial_clock_in : serial_clock_out),
		.mosi(serial_out_pin), .miso(serial_in_pin),
		.pol(clock_polarity_bit), .pha(clock_phase_bit), .load, .tx_word(s_word), .rx_word(m_word));
	// ****************
	// shared tasks
	// ****************
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			stop_test();
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask
	task pulse(input int which);
		@(posedge mclk);
		if (which == 0) irq_clear_wr <= 1'b1;
		else data_low_rd <= 1'b1;
		@(posedge mclk);
		irq_clear_wr <= 1'b0;
		data_low_rd <= 1'b0;
		#1;
	endtask
	task wr(input logic hi, input logic [15:0] d);
		@(posedge mclk);
		data_high_wr <= hi;
		data_low_wr <= !hi;
		wr_data <= d;
		@(posedge mclk);
		data_high_wr <= 1'b0;
		data_low_wr <= 1'b0;
		#1;
	endtask
	// enable goes up only after the mode is settled; model held in load over the clock idle change
	task cfg(input logic [1:0] md, ws, dv, fm, input logic [31:0] sw);
		@(posedge mclk);
		ctrl_enable_bit <= 1'b0;
		{clock_polarity_bit, clock_phase_bit} <= md;
		word_size_sel <= ws;
		clock_div_sel <= dv;
		fifo_mode_sel <= fm;
		s_word <= sw;
		load <= 1'b1;
		repeat (2) @(posedge mclk);
		load <= 1'b0;
		ctrl_enable_bit <= 1'b1;
	endtask
	task wait_end(output int gap);
		int last, i;
		logic prev;
		last = 0;
		gap = 0;
		prev = serial_clock_out;
		for (i = 0; i < 3000 && irq_pending_flag !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
			if (serial_clock_out !== prev) begin
				gap = i - last;
				last = i;
				prev = serial_clock_out;
			end
		end
		repeat (2) @(posedge mclk);
		#1;
	endtask
	// ****************
	// scenarios
	// ****************
	task t_xfer(input int k);
		logic [1:0] ws, md;
		logic [5:0] n;
		logic [31:0] w, s, mk;
		int gap;
		md = 2'(k % 4);
		ws = 2'((k + k / 4) % 4);
		n = SPMF_BITS_TAB[ws];
		w = 32'h9c3a6d51;
		s = 32'h5ac3e712;
		mk = 32'hffffffff >> (6'd32 - ((n == 6'h09) ? 6'h08 : n));
		@(posedge mclk);
		idle_level_bit <= k[2];
		irq_mask_bit <= k[0];
		ninth_bit_cmd_data <= k[0];
		cfg(md, ws, 2'(k % 4), SPMF_FM_NONE, s << (6'd32 - n));
		if (ws == SPMF_WS_32) wr(1'b1, w[31:16]);
		wr(1'b0, w[15:0]);
		check(tx_holding_full_flag, 1, "hold set");
		@(posedge mclk);
		#1;
		check(tx_holding_full_flag, 0, "hold clear");
		check(serial_clock_oe, 1, "clock pin out");
		wait_end(gap);
		check(gap, SPMF_HALF_TAB[clock_div_sel], "half period");
		check(m_word, (ws == SPMF_WS_9) ? {23'h0, k[0], w[7:0]} : w & mk, "sent");
		check(data_low_register, s[15:0] & mk[15:0], "low data");
		if (ws == SPMF_WS_32) check(data_high_register, s[31:16], "high data");
		check(irq, !k[0], "irq");
		check(serial_clock_out, md[1], "clock idle");
		check(serial_out_pin, md[0] ? w[0] : k[2], "out after word");
		if (md[0]) begin
			@(posedge mclk);
			force_output_bit <= 1'b1;
			@(posedge mclk);
			#1;
			check(serial_out_pin, k[2], "forced");
			@(posedge mclk);
			force_output_bit <= 1'b0;
			engine_reset_bit <= 1'b1;
			@(posedge mclk);
			engine_reset_bit <= 1'b0;
			#1;
			check(serial_out_pin, k[2], "reset out");
		end
		pulse(0);
		check(irq_pending_flag, 0, "cleared");
		$display("test xfer %0d done", k);
	endtask
	task t_wronly;
		int i;
		cfg(2'h0, SPMF_WS_8, 2'h2, SPMF_FM_WRONLY, 32'h5a5a5a5a);
		#1;
		check(irq_status_bit, 1, "tx request");
		check(tx_dma_req, 1, "tx dma");
		for (i = 0; i < 5; i++) begin
			@(posedge mclk);
			data_low_wr <= 1'b1;
			wr_data <= 16'(16'h10 + i);
		end
		@(posedge mclk);
		data_low_wr <= 1'b0;
		#1;
		check(tx_holding_full_flag, 1, "fifo full");
		check(irq_status_bit, 0, "no request");
		for (i = 0; i < 3000 && busy_flag !== 1'b0; i++) @(posedge mclk);
		repeat (2) @(posedge mclk);
		#1;
		check(busy_flag, 0, "busy end");
		check(m_word[7:0], 8'h14, "last sent");
		check(data_low_register[7:0], 8'h5a, "rx word");
		$display("test writes only done");
	endtask
	task t_rdonly;
		int i;
		@(posedge mclk);
		srst <= 1'b1;
		@(posedge mclk);
		srst <= 1'b0;
		cfg(2'h0, SPMF_WS_8, 2'h1, SPMF_FM_RDONLY, 32'h5a5a5a5a);
		repeat (4) @(posedge mclk);
		for (i = 0; i < 3000 && busy_flag !== 1'b0; i++) @(posedge mclk);
		#1;
		check(busy_flag, 0, "stop on full");
		check(rx_dma_req, 1, "rx dma");
		check(m_word, 0, "zeros sent");
		@(posedge mclk);
		fifo_mode_sel <= SPMF_FM_BIDIR;
		pulse(0);
		check(irq_status_bit, 1, "unread holds irq");
		for (i = 0; i < 4; i++) begin
			check(data_low_register[7:0], 8'h5a, "rx fifo");
			pulse(1);
		end
		pulse(0);
		check(irq_status_bit, 0, "four words only");
		$display("test reads only done");
	endtask
	task t_bidir;
		int i;
		cfg(2'h3, SPMF_WS_16, 2'h2, SPMF_FM_BIDIR, 32'h5a5a5a5a);
		wr(1'b0, 16'hc3e1);
		for (i = 0; i < 3000 && irq_status_bit !== 1'b1; i++) @(posedge mclk);
		repeat (3) @(posedge mclk);
		#1;
		check(data_low_register, 16'h5a5a, "rx head");
		check(m_word[15:0], 16'hc3e1, "sent");
		pulse(1);
		pulse(0);
		check(irq_status_bit, 0, "rx empty");
		$display("test bidirectional done");
	endtask
	task t_slave;
		int i;
		@(posedge mclk);
		slave_select_mode_bit <= 1'b1;
		chip_enable_ctrl_bit <= 1'b1;
		first_port_chip_enable_n <= 1'b0;
		cfg(2'h0, SPMF_WS_8, 2'h0, SPMF_FM_NONE, 32'ha5000000);
		#1;
		check(serial_clock_oe, 0, "clock pin input");
		wr(1'b0, 16'h00c3);
		for (i = 0; i < 16; i++) begin
			repeat (4) @(posedge mclk);
			serial_clock_in <= !serial_clock_in;
		end
		repeat (3) @(posedge mclk);
		#1;
		check(irq_pending_flag, 1, "slave word");
		check(data_low_register, 16'h00a5, "slave rx");
		check(m_word[7:0], 8'hc3, "slave tx");
		pulse(0);
		wr(1'b0, 16'h003c);
		for (i = 0; i < 4; i++) begin
			repeat (4) @(posedge mclk);
			serial_clock_in <= !serial_clock_in;
		end
		@(posedge mclk);
		first_port_chip_enable_n <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		check(busy_flag, 0, "abort idle");
		check(irq_pending_flag, 0, "no word end");
		$display("test slave done");
	endtask
	initial begin
		int k;
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		#1;
		check(serial_out_pin, idle_level_bit, "reset out");
		check(irq_pending_flag, 0, "reset pend");
		for (k = 0; k < 8; k++) t_xfer(k);
		t_wronly();
		t_rdonly();
		t_bidir();
		t_slave();
		stop_test();
	end
endmodule // spi_master_slave_fifo_port_test
